// ### hw/msbi_defs.vh
// Constants for the motion status bit image
`ifndef MSBI_DEFS_VH
`define MSBI_DEFS_VH
`define MSBI_IMG_W        80
`define MSBI_OFS_ERR      0
`define MSBI_OFS_LLOGIC   1
`define MSBI_OFS_NEWCFG   2
`define MSBI_OFS_GPI_LO   4
`define MSBI_OFS_GPI_HI   12
`define MSBI_OFS_AXIS1    16
`define MSBI_AXIS_W       16
`define MSBI_NUM_AXES     4
`define MSBI_GPI_N        12
`define MSBI_SRC_N        32
`define MSBI_SRC_SEL_W    5
`define MSBI_CODE_W       16
`define MSBI_CMD_W        8
`define MSBI_CMD_CLR_NEWCFG 8'h49
`define MSBI_FLD_TORQUE   9
`define MSBI_FLD_SRDY     10
`define MSBI_FLD_RSV0     11
`define MSBI_FLD_RSV1     15
`endif

// ### hw/msbi_status_image.v
// Status bit image of a four-axis motion module, captured once per host scan
// Functional notes
// - Full image is captured and presented every host scan, no host action needed.
// - Each bit sits at a fixed offset from the host-configured start address.
// - Axis 1 group spans offsets 16 to 31 in documented field order.
// - Axes 2-4 repeat the group at 32, 48, 64; axes 3,4 torque reserved.
// - Error present bit at offset 0 sets on any module or axis error.
// - Axis error writes an identifying code into that axis's error code word.
// - Module-wide error writes its code into the module status code word.
// - Only the clear-error command clears error bit and all error codes.
// - Clear-error while cause persists leaves the error present bit set.
// - Local logic active bit at offset 1 follows the running local program.
// - New configuration bit sets on host reset command or new configuration.
// - New configuration bit clears only on immediate command 49h.
// - Twelve configurable general input bits report their selected source state.
// - Default source of each general input bit is a faceplate input level.
// - Source of each general input bit comes from configuration, not fixed logic.
// - General input bits are offered to motion program wait and jump tests.
// - General input bits are offered as follower ramp enable/disable triggers.
// - Image is 32, 48, 64 or 80 bits for one to four axes; here always 80 bits, groups of unused axes read zero.
`timescale 1ns/1ps
`include "msbi_defs.vh"
module msbi_status_image
(
   input  wire                         clk,
   input  wire                         rst,
   input  wire                         scan_strobe,
   input  wire [2:0]                   axis_count,
   input  wire [`MSBI_IMG_W-1:0]       host_start_unused,
   input  wire                         local_logic_running,
   input  wire                         host_reset_cmd,
   input  wire                         host_new_config,
   input  wire                         imm_cmd_valid,
   input  wire [`MSBI_CMD_W-1:0]       imm_cmd_code,
   input  wire                         clear_error_cmd,
   input  wire                         module_err_event,
   input  wire [`MSBI_CODE_W-1:0]      module_err_code,
   input  wire                         module_err_cond,
   input  wire [`MSBI_NUM_AXES-1:0]    axis_err_event,
   input  wire [4*`MSBI_CODE_W-1:0]    axis_err_code_in,
   input  wire [`MSBI_NUM_AXES-1:0]    axis_err_cond,
   input  wire [4*`MSBI_AXIS_W-1:0]    axis_status_in,
   input  wire [`MSBI_NUM_AXES-1:0]    servo_ready_pins,
   input  wire [`MSBI_SRC_N-1:0]       gpi_sources,
   input  wire [`MSBI_GPI_N*`MSBI_SRC_SEL_W-1:0] gpi_src_sel,
   output reg  [`MSBI_IMG_W-1:0]       status_image,
   output reg                          image_valid,
   output reg  [`MSBI_CODE_W-1:0]      module_status_code,
   output reg  [4*`MSBI_CODE_W-1:0]    axis_error_code,
   output reg  [`MSBI_GPI_N-1:0]       gpi_bits,
   output reg                          error_present,
   output reg                          new_config_received
);

   // Axis slots, counted from zero
   localparam [2:0] AX1 = 3'h0;
   localparam [2:0] AX2 = 3'h1;
   localparam [2:0] AX3 = 3'h2;
   localparam [2:0] AX4 = 3'h3;

   // Two-flop synchronisers, working copies and per-axis code words
   reg  [`MSBI_NUM_AXES-1:0] srdy_s1_r;
   reg  [`MSBI_NUM_AXES-1:0] srdy_s2_r;
   reg  [`MSBI_SRC_N-1:0]    src_s1_r;
   reg  [`MSBI_SRC_N-1:0]    src_s2_r;
   reg  [`MSBI_IMG_W-1:0]    image_nxt;
   reg  [`MSBI_GPI_N-1:0]    gpi_nxt;
   reg  [`MSBI_AXIS_W-1:0]   grp0_nxt;
   reg  [`MSBI_AXIS_W-1:0]   grp1_nxt;
   reg  [`MSBI_AXIS_W-1:0]   grp2_nxt;
   reg  [`MSBI_AXIS_W-1:0]   grp3_nxt;
   reg  [`MSBI_CODE_W-1:0]   axis_code0_r;
   reg  [`MSBI_CODE_W-1:0]   axis_code1_r;
   reg  [`MSBI_CODE_W-1:0]   axis_code2_r;
   reg  [`MSBI_CODE_W-1:0]   axis_code3_r;
   reg                       err_cond_any;
   reg                       err_evt_any;

   // Source select per general input bit, table driven by configuration
   function src_pick;
      input [`MSBI_SRC_N-1:0]     srcs;
      input [`MSBI_SRC_SEL_W-1:0] sel;
      begin
         src_pick = srcs[sel];
      end
   endfunction

   // Axis slot is shown only when the configured axis count covers it
   function axis_on;
      input [2:0] count;
      input [2:0] idx;
      begin
         axis_on = (count > idx);
      end
   endfunction

   // One axis group with servo ready, reserved and torque fields applied
   function [`MSBI_AXIS_W-1:0] axis_group;
      input [`MSBI_AXIS_W-1:0] raw;
      input                    srdy;
      input                    on;
      input                    torque_kept;
      begin
         axis_group = {`MSBI_AXIS_W{1'b0}};
         if (on)
         begin
            axis_group = raw;
            axis_group[`MSBI_FLD_SRDY] = srdy;
            axis_group[`MSBI_FLD_RSV0] = 1'b0;
            axis_group[`MSBI_FLD_RSV1] = 1'b0;
            if (!torque_kept)
               axis_group[`MSBI_FLD_TORQUE] = 1'b0;
         end
      end
   endfunction

   // Servo ready pins are asynchronous, so two flops before use
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         srdy_s1_r <= 4'h0;
         srdy_s2_r <= 4'h0;
      end
      else
      begin
         srdy_s1_r <= servo_ready_pins;
         srdy_s2_r <= srdy_s1_r;
      end
   end

   // Faceplate sources likewise; only the second flop is read
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         src_s1_r <= 32'h0;
         src_s2_r <= 32'h0;
      end
      else
      begin
         src_s1_r <= gpi_sources;
         src_s2_r <= src_s1_r;
      end
   end

   // General inputs follow their configured source; faceplate levels by default
   always @*
   begin
      gpi_nxt[0]  = src_pick(src_s2_r, gpi_src_sel[4:0]);
      gpi_nxt[1]  = src_pick(src_s2_r, gpi_src_sel[9:5]);
      gpi_nxt[2]  = src_pick(src_s2_r, gpi_src_sel[14:10]);
      gpi_nxt[3]  = src_pick(src_s2_r, gpi_src_sel[19:15]);
      gpi_nxt[4]  = src_pick(src_s2_r, gpi_src_sel[24:20]);
      gpi_nxt[5]  = src_pick(src_s2_r, gpi_src_sel[29:25]);
      gpi_nxt[6]  = src_pick(src_s2_r, gpi_src_sel[34:30]);
      gpi_nxt[7]  = src_pick(src_s2_r, gpi_src_sel[39:35]);
      gpi_nxt[8]  = src_pick(src_s2_r, gpi_src_sel[44:40]);
      gpi_nxt[9]  = src_pick(src_s2_r, gpi_src_sel[49:45]);
      gpi_nxt[10] = src_pick(src_s2_r, gpi_src_sel[54:50]);
      gpi_nxt[11] = src_pick(src_s2_r, gpi_src_sel[59:55]);
   end

   // Any live error condition across module and axes
   always @*
   begin
      err_cond_any = module_err_cond | (|axis_err_cond);
      err_evt_any  = module_err_event | (|axis_err_event);
   end

   // Error flag; a new event beats a clear, a live cause survives it
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         error_present <= 1'b0;
      end
      else
      begin
         if (clear_error_cmd)
            error_present <= err_cond_any;
         if (err_evt_any)
            error_present <= 1'b1;
      end
   end

   // Module status code, loaded in the same cycle as the flag
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         module_status_code <= 16'h0000;
      end
      else
      begin
         if (clear_error_cmd)
            module_status_code <= 16'h0000;
         if (module_err_event)
            module_status_code <= module_err_code;
      end
   end

   // Axis 1 error code; a fresh code beats a clear in the same cycle
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         axis_code0_r <= 16'h0000;
      end
      else
      begin
         if (clear_error_cmd)
            axis_code0_r <= 16'h0000;
         if (axis_err_event[0])
            axis_code0_r <= axis_err_code_in[15:0];
      end
   end

   // Axis 2 error code
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         axis_code1_r <= 16'h0000;
      end
      else
      begin
         if (clear_error_cmd)
            axis_code1_r <= 16'h0000;
         if (axis_err_event[1])
            axis_code1_r <= axis_err_code_in[31:16];
      end
   end

   // Axis 3 error code
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         axis_code2_r <= 16'h0000;
      end
      else
      begin
         if (clear_error_cmd)
            axis_code2_r <= 16'h0000;
         if (axis_err_event[2])
            axis_code2_r <= axis_err_code_in[47:32];
      end
   end

   // Axis 4 error code
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         axis_code3_r <= 16'h0000;
      end
      else
      begin
         if (clear_error_cmd)
            axis_code3_r <= 16'h0000;
         if (axis_err_event[3])
            axis_code3_r <= axis_err_code_in[63:48];
      end
   end

   // Four code words presented as one port, still straight from flops
   always @*
   begin
      axis_error_code = {axis_code3_r, axis_code2_r, axis_code1_r, axis_code0_r};
   end

   // New configuration flag; set wins over the 49h clear
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         new_config_received <= 1'b0;
      else if (host_reset_cmd || host_new_config)
         new_config_received <= 1'b1;
      else if (imm_cmd_valid && imm_cmd_code == `MSBI_CMD_CLR_NEWCFG)
         new_config_received <= 1'b0;
   end

   // Axis 1 group, shown whenever at least one axis is configured
   always @*
   begin
      grp0_nxt = axis_group(axis_status_in[15:0], srdy_s2_r[0], axis_on(axis_count, AX1), 1'b1);
   end

   // Axis 2 group keeps its torque limit bit
   always @*
   begin
      grp1_nxt = axis_group(axis_status_in[31:16], srdy_s2_r[1], axis_on(axis_count, AX2), 1'b1);
   end

   // Axes 3 and 4 have no torque limit, so that field reads zero
   always @*
   begin
      grp2_nxt = axis_group(axis_status_in[47:32], srdy_s2_r[2], axis_on(axis_count, AX3), 1'b0);
   end

   // Axis 4 group
   always @*
   begin
      grp3_nxt = axis_group(axis_status_in[63:48], srdy_s2_r[3], axis_on(axis_count, AX4), 1'b0);
   end

   // Assemble the image; unused axis groups and reserved bits stay zero
   always @*
   begin
      image_nxt = {`MSBI_IMG_W{1'b0}};
      image_nxt[`MSBI_OFS_ERR]    = error_present;
      image_nxt[`MSBI_OFS_LLOGIC] = local_logic_running;
      image_nxt[`MSBI_OFS_NEWCFG] = new_config_received;
      image_nxt[`MSBI_OFS_GPI_LO +: 8] = gpi_bits[7:0];
      image_nxt[`MSBI_OFS_GPI_HI +: 4] = gpi_bits[11:8];
      image_nxt[`MSBI_OFS_AXIS1 +: `MSBI_AXIS_W] = grp0_nxt;
      image_nxt[`MSBI_OFS_AXIS1 + `MSBI_AXIS_W +: `MSBI_AXIS_W] = grp1_nxt;
      image_nxt[`MSBI_OFS_AXIS1 + 2*`MSBI_AXIS_W +: `MSBI_AXIS_W] = grp2_nxt;
      image_nxt[`MSBI_OFS_AXIS1 + 3*`MSBI_AXIS_W +: `MSBI_AXIS_W] = grp3_nxt;
   end

   // General inputs registered once; costs a cycle, keeps the image glitch free
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         gpi_bits <= 12'h000;
      else
         gpi_bits <= gpi_nxt;
   end

   // Valid follows the scan by one cycle
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         image_valid <= 1'b0;
      else
         image_valid <= scan_strobe;
   end

   // Snapshot on each scan so the host never sees a torn image
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         status_image <= 80'h0;
      else if (scan_strobe)
         status_image <= image_nxt;
   end

endmodule

// ### testbench/msbi_chk_asserts.sv
// Assertions on the status image ports
`timescale 1ns/1ps
module msbi_chk
(
   input logic        clk,
   input logic        rst,
   input logic        scan_strobe,
   input logic        local_logic_running,
   input logic        host_reset_cmd,
   input logic        host_new_config,
   input logic        imm_cmd_valid,
   input logic [7:0]  imm_cmd_code,
   input logic        clear_error_cmd,
   input logic        module_err_event,
   input logic [15:0] module_err_code,
   input logic        module_err_cond,
   input logic [79:0] status_image,
   input logic        image_valid,
   input logic [15:0] module_status_code,
   input logic        error_present,
   input logic        new_config_received
);
   // One domain, so reset masks all checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_scan_valid: assert property (scan_strobe |=> image_valid)
      else $error("no valid after scan");
   a_image_hold: assert property (!scan_strobe |=> $stable(status_image))
      else $error("image moved between scans");
   a_err_code: assert property (module_err_event |=> error_present && module_status_code == $past(module_err_code))
      else $error("flag or code missing");
   a_err_image: assert property (scan_strobe |=> status_image[0] == $past(error_present))
      else $error("error bit wrong in image");
   a_err_sticky: assert property (error_present && !clear_error_cmd |=> error_present)
      else $error("error cleared without command");
   a_clear_cond: assert property (clear_error_cmd && module_err_cond |=> error_present)
      else $error("error cleared while cause held");
   a_newcfg_set: assert property (host_reset_cmd || host_new_config |=> new_config_received)
      else $error("new config bit not set");
   a_newcfg_keep: assert property (new_config_received && !(imm_cmd_valid && imm_cmd_code == 8'h49) |=> new_config_received)
      else $error("new config bit lost");
   a_llogic_bit: assert property (scan_strobe |=> status_image[1] == $past(local_logic_running))
      else $error("local logic bit wrong");
   a_rsv_zero: assert property (image_valid |-> !status_image[3] && !status_image[27] && !status_image[79])
      else $error("reserved bit set");
   // Main scenarios reached
   c_clear_held: cover property (clear_error_cmd && module_err_cond);
   c_newcfg_clr: cover property (imm_cmd_valid && imm_cmd_code == 8'h49 && new_config_received);
   c_err_scan: cover property (image_valid && status_image[0]);
endmodule
bind msbi_status_image msbi_chk msbi_chk_inst (.*);

// ### testbench/msbi_host_model.sv
// Host model that scans the status image
`timescale 1ns/1ps
module msbi_host_model
(
   input  logic        clk,
   input  logic        image_valid,
   input  logic [79:0] status_image,
   output logic        scan_strobe,
   output logic [79:0] snap
);
   initial scan_strobe = 1'b0;
   // One scan: strobe a cycle, keep the image only if valid shows
   task scan;
      @(posedge clk) #1 scan_strobe = 1'b1;
      @(posedge clk) #1 scan_strobe = 1'b0;
      snap = image_valid ? status_image : 80'h0;
   endtask
endmodule

// ### testbench/msbi_status_image_test.sv
// Self-checking bench for the status image
`timescale 1ns/1ps
module msbi_status_image_test;
   logic        clk = 1'b0, rst = 1'b1, scan_strobe, image_valid, error_present, new_config_received;
   logic        local_logic_running = 1'b1, host_reset_cmd = 1'b0, host_new_config = 1'b0, imm_cmd_valid = 1'b0;
   logic        clear_error_cmd = 1'b0, module_err_event = 1'b0, module_err_cond = 1'b0;
   logic [2:0]  axis_count = 3'h4;
   logic [7:0]  imm_cmd_code = 8'h00;
   logic [15:0] module_err_code = 16'h1234, module_status_code;
   logic [3:0]  axis_err_event = 4'h0, axis_err_cond = 4'h0, servo_ready_pins = 4'hf;
   logic [63:0] axis_err_code_in = 64'h0c0d_0000_0000, axis_status_in = {4{16'hffff}}, axis_error_code;
   logic [79:0] host_start_unused = 80'h0, status_image, snap;
   logic [31:0] gpi_sources = 32'ha5c3_0000;
   logic [59:0] gpi_src_sel;
   logic [11:0] gpi_bits;
   int          bad_count = 0, checks_done = 0;
   // Input bit k taken from source 31-k, so the order shows up reversed
   initial for (int k = 0; k < 12; k++) gpi_src_sel[5*k+:5] = 5'(31 - k);
   always #2 clk = ~clk;
   msbi_status_image msbi_status_image_inst (.*);
   msbi_host_model   msbi_host_model_inst (.*);
   task check(string name, logic [79:0] seen, logic [79:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task conclude;
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One-cycle request, entered just after an edge
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge clk) #1 s = 1'b0;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      check("reset", {error_present, new_config_received, module_status_code}, 80'h0);
      repeat (4) @(posedge clk);
      msbi_host_model_inst.scan;
      check("image", snap, {16'h75ff, 16'h75ff, 16'h77ff, 16'h77ff, 16'h3a52});
      axis_count = 3'h2;
      msbi_host_model_inst.scan;
      check("two axes", snap, {32'h0, 16'h77ff, 16'h77ff, 16'h3a52});
      check("gpi bits", gpi_bits, 80'h3a5);
      servo_ready_pins = 4'h0;
      local_logic_running = 1'b0;
      repeat (2) @(posedge clk);
      msbi_host_model_inst.scan;
      check("ready low", snap, {32'h0, 16'h73ff, 16'h73ff, 16'h3a50});
      module_err_cond = 1'b1;
      pulse(module_err_event);
      check("mod err", {error_present, module_status_code}, 80'h1_1234);
      msbi_host_model_inst.scan;
      check("err bit", snap[0], 80'h1);
      pulse(clear_error_cmd);
      check("held err", {error_present, module_status_code}, 80'h1_0000);
      module_err_cond = 1'b0;
      axis_err_event = 4'h4;
      @(posedge clk) #1 axis_err_event = 4'h0;
      check("axis err", {error_present, axis_error_code[47:32]}, 80'h1_0c0d);
      pulse(clear_error_cmd);
      check("cleared", {error_present, axis_error_code}, 80'h0);
      pulse(host_reset_cmd);
      imm_cmd_code = 8'h48;
      pulse(imm_cmd_valid);
      check("other code", new_config_received, 80'h1);
      imm_cmd_code = 8'h49;
      pulse(imm_cmd_valid);
      check("cfg clear", new_config_received, 80'h0);
      pulse(host_new_config);
      msbi_host_model_inst.scan;
      check("cfg bit", snap[2], 80'h1);
      conclude;
   end
   // Watchdog well beyond the thirty or so cycles the tests take
   initial
   begin
      repeat (2000) @(posedge clk);
      bad_count++;
      conclude;
   end
endmodule
